// ---- common/asr_brg_if.sv ----
// Purpose: link between receiver core and bit rate generator
// Assumes: one clock domain
// Notes:   core drives configuration, generator returns tick and ratio

`timescale 1ns/10ps

interface asr_brg_if;
   import asr_pkg::*;
   logic [SEL_W-1:0] clk_sel;
   logic             ext_sel;
   logic             dbl;
   logic             half;
   logic             six;
   logic [DW-1:0]    divisor;
   logic             ext_clk_s;
   logic             tick;
   logic [SPB_W-1:0] spb;

   modport brg (
      input  clk_sel, ext_sel, dbl, half, six, divisor, ext_clk_s,
      output tick, spb
   );
   modport core (
      output clk_sel, ext_sel, dbl, half, six, divisor, ext_clk_s,
      input  tick, spb
   );
endinterface

// ---- common/asr_pkg.sv ----
// Purpose: constants and types of the serial receiver with bit rate generator
// Assumes: 8-bit register port, byte-wide registers
// Notes:   offsets are byte addresses on the register port

package asr_pkg;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam int          AW            = 8;
   localparam int          DW            = 8;
   localparam logic [7:0]  ADDR_CTRL     = 8'h00;
   localparam logic [7:0]  ADDR_DIV      = 8'h04;
   localparam logic [7:0]  ADDR_STAT     = 8'h08;
   localparam logic [7:0]  ADDR_DATA     = 8'h0c;
   localparam logic [7:0]  ADDR_IRQ      = 8'h10;
   localparam logic [7:0]  ADDR_MASK     = 8'h14;

   // ****************************************************************
   // serial_control_word fields
   // ****************************************************************
   localparam int          CTL_RX_ALLOW  = 0;
   localparam int          CTL_IRQ_ALLOW = 1;
   localparam int          CTL_SEL_LO    = 2;
   localparam int          CTL_SEL_HI    = 3;
   localparam int          CTL_EXT       = 4;
   localparam int          CTL_DBL       = 5;
   localparam int          CTL_HALF      = 6;
   localparam int          CTL_SIX       = 7;
   localparam logic [7:0]  CTRL_RST      = 8'h00;
   localparam logic [7:0]  DIV_RST       = 8'h00;

   // ****************************************************************
   // serial_status_word and interrupt fields
   // ****************************************************************
   localparam int          ERR_W         = 2;
   localparam int          STA_OVR       = 0;
   localparam int          STA_FRM       = 1;
   localparam int          IRQ_W         = 2;
   localparam int          IRQ_FULL      = 0;
   localparam int          IRQ_FAULT     = 1;
   localparam logic [1:0]  MASK_RST      = 2'h0;

   // ****************************************************************
   // bit rate generator
   // ****************************************************************
   localparam int          SEL_W         = 2;
   localparam logic [1:0]  SEL_DIV1      = 2'h0;
   localparam logic [1:0]  SEL_DIV4      = 2'h1;
   localparam logic [1:0]  SEL_DIV16     = 2'h2;
   localparam logic [1:0]  SEL_DIV64     = 2'h3;
   localparam int          PRE_W         = 6;
   localparam logic [5:0]  PRE_TOP1      = 6'h00;
   localparam logic [5:0]  PRE_TOP4      = 6'h03;
   localparam logic [5:0]  PRE_TOP16     = 6'h0f;
   localparam logic [5:0]  PRE_TOP64     = 6'h3f;
   localparam int          SPB_W         = 6;
   localparam logic [5:0]  SPB_32        = 6'h20;
   localparam logic [5:0]  SPB_16        = 6'h10;
   localparam logic [5:0]  SPB_8         = 6'h08;
   localparam logic [5:0]  SPB_6         = 6'h06;
   localparam logic [3:0]  DATA_LAST     = 4'h7;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_START = 2'b01,
      ST_DATA  = 2'b10,
      ST_STOP  = 2'b11
   } asr_state_t;

endpackage

// ---- logic/asr_brg.sv ----
// Purpose: bit rate generator, prescaler, divisor and base clock ratio
// Assumes: external clock input already synchronised
// Notes:   tick is one base clock period, spb base ticks form one bit

`timescale 1ns/10ps

module asr_brg
   import asr_pkg::*;
(
   input  wire logic clock_i,
   input  wire logic rstn_i,
   asr_brg_if.brg    cfg
);

   // ****************************************************************
   // prescaler
   // ****************************************************************
   logic [PRE_W-1:0] pre_q;
   logic [PRE_W-1:0] pre_d;
   logic [PRE_W-1:0] pre_top;
   logic             pre_en;
   logic [DW-1:0]    div_q;
   logic [DW-1:0]    div_d;
   logic             div_hit;
   logic             ext_old_q;
   logic             ext_rise;
   logic             tick_q;

   // pclk divided by two to the power 2n
   assign pre_top = (cfg.clk_sel == SEL_DIV1)  ? PRE_TOP1  :
                    (cfg.clk_sel == SEL_DIV4)  ? PRE_TOP4  :
                    (cfg.clk_sel == SEL_DIV16) ? PRE_TOP16 : PRE_TOP64;
   assign pre_en  = (pre_q >= pre_top);
   assign pre_d   = pre_en ? '0 : pre_q + 1'b1;

   // divisor counts N+1 prescaled clocks
   assign div_hit  = pre_en && (div_q >= cfg.divisor);
   assign div_d    = div_hit ? '0 : (pre_en ? div_q + 1'b1 : div_q);
   assign ext_rise = cfg.ext_clk_s && !ext_old_q;

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         pre_q     <= '0;
         div_q     <= '0;
         ext_old_q <= 1'b0;
         tick_q    <= 1'b0;
      end else begin
         pre_q     <= pre_d;
         div_q     <= div_d;
         ext_old_q <= cfg.ext_clk_s;
         tick_q    <= cfg.ext_sel ? ext_rise : div_hit;
      end
   end

   // ****************************************************************
   // base clocks per bit
   // ****************************************************************
   assign cfg.tick = tick_q;
   assign cfg.spb  = cfg.six                 ? SPB_6  :
                     cfg.ext_sel             ? (cfg.half ? SPB_8 : SPB_16) :
                     (cfg.dbl && cfg.half)   ? SPB_8  :
                     (cfg.dbl || cfg.half)   ? SPB_16 :
                                               SPB_32;

   AST_SPB32: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !cfg.six && !cfg.ext_sel && !cfg.dbl && !cfg.half |-> cfg.spb == SPB_32)
      else $error("ratio not 32 in default mode");
   AST_SPB16: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !cfg.six && !cfg.ext_sel && (cfg.dbl ^ cfg.half) |-> cfg.spb == SPB_16)
      else $error("ratio not 16 with one select");
   AST_SPB8: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !cfg.six && !cfg.ext_sel && cfg.dbl && cfg.half |-> cfg.spb == SPB_8)
      else $error("ratio not 8 with both selects");
   AST_SPB6: assert property (@(posedge clock_i) disable iff (!rstn_i)
      cfg.six |-> cfg.spb == SPB_6)
      else $error("ratio not 6 with six clock base");
   AST_PRE1: assert property (@(posedge clock_i) disable iff (!rstn_i)
      cfg.clk_sel == SEL_DIV1 && $past(cfg.clk_sel) == SEL_DIV1 |-> pre_en)
      else $error("undivided source missing enable");
   AST_PRE4: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (pre_en && cfg.clk_sel == SEL_DIV4) ##1 (cfg.clk_sel == SEL_DIV4)[*4]
      |-> pre_en && $past(!pre_en, 1) && $past(!pre_en, 3))
      else $error("divide by four spacing wrong");
   AST_EXT: assert property (@(posedge clock_i) disable iff (!rstn_i)
      cfg.ext_sel && !cfg.six |-> cfg.spb == (cfg.half ? SPB_8 : SPB_16))
      else $error("external clock ratio wrong");

endmodule

// ---- logic/asr_top.sv ----
// Purpose: asynchronous serial receiver with bit rate generator
// Assumes: 8 data bits, one stop bit, no parity, lsb first
// Notes:   error flags block reception until software clears them
//
// The implementer's own choices: the register addresses and strobed register access.

`timescale 1ns/10ps

// Operation
// - receive only while rx_allow is set
// - start bit on line begins a character
// - complete byte stored, full pending flag set
// - errors raise fault interrupt, not full
// - error flags cleared by zero after read
// - all flags clear drops fault, resumes reception
// - default ratio: source over 32(N+1)
// - one select set: source over 16(N+1)
// - both selects set: source over 8(N+1)
// - six clock base: source over 6(N+1)
// - source is pclk over 1,4,16,64
// - prescale setting n divides by 2^(2n)
// - external clock over 16, or 8 with halving, or 6 with six clock base
module asr_top
   import asr_pkg::*;
(
   input  wire logic          clock_i,
   input  wire logic          rstn_i,
   input  wire logic [AW-1:0] addr_i,
   input  wire logic [DW-1:0] wdata_i,
   input  wire logic          wr_i,
   input  wire logic          rd_i,
   output logic      [DW-1:0] rdata_o,
   input  wire logic          rxd_i,
   input  wire logic          ext_clock_pin_i,
   output logic               rx_full_irq_o,
   output logic               rx_fault_irq_o,
   output logic               irq_o
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   logic [DW-1:0]    ctrl_q;
   logic [DW-1:0]    divisor_value_q;
   logic [ERR_W-1:0] err_q;
   logic [ERR_W-1:0] err_d;
   logic [ERR_W-1:0] seen_q;
   logic [ERR_W-1:0] seen_d;
   logic [ERR_W-1:0] err_set;
   logic [ERR_W-1:0] err_clr;
   logic [DW-1:0]    rxbuf_q;
   logic             full_q;
   logic             full_d;
   logic             fault_q;
   logic [IRQ_W-1:0] irq_gate_q;
   logic [DW-1:0]    rdata_q;
   logic             rx_full_irq_q;
   logic             rx_fault_irq_q;
   logic             irq_q;
   logic             rxd_m_q;
   logic             rxd_s_q;
   logic             ext_m_q;
   logic             ext_s_q;
   asr_state_t       st_q;
   asr_state_t       st_d;
   logic [SPB_W-1:0] cnt_q;
   logic [SPB_W-1:0] cnt_d;
   logic [3:0]       bit_q;
   logic [3:0]       bit_d;
   logic [DW-1:0]    sh_q;
   logic [DW-1:0]    sh_d;
   logic             stop_smp;
   logic             done_ok;
   logic             frm_evt;
   logic             ovr_evt;
   logic             err_evt;
   logic [SPB_W-1:0] half_m1;
   logic [SPB_W-1:0] spb_m1;
   logic             rx_allow;
   logic             tick;

   asr_brg_if brg_if ();

   // ****************************************************************
   // register port decode
   // ****************************************************************
   logic             wr_ctrl;
   logic             wr_div;
   logic             wr_stat;
   logic             wr_irq;
   logic             wr_mask;
   logic             rd_stat;
   logic [DW-1:0]    rd_mux;

   assign wr_ctrl = wr_i && (addr_i == ADDR_CTRL);
   assign wr_div  = wr_i && (addr_i == ADDR_DIV);
   assign wr_stat = wr_i && (addr_i == ADDR_STAT);
   assign wr_irq  = wr_i && (addr_i == ADDR_IRQ);
   assign wr_mask = wr_i && (addr_i == ADDR_MASK);
   assign rd_stat = rd_i && (addr_i == ADDR_STAT);

   // unmapped addresses read as zero
   assign rd_mux =
      (addr_i == ADDR_CTRL) ? ctrl_q :
      (addr_i == ADDR_DIV)  ? divisor_value_q :
      (addr_i == ADDR_STAT) ? {{(DW-ERR_W){1'b0}}, err_q} :
      (addr_i == ADDR_DATA) ? rxbuf_q :
      (addr_i == ADDR_IRQ)  ? {{(DW-IRQ_W){1'b0}}, fault_q, full_q} :
      (addr_i == ADDR_MASK) ? {{(DW-IRQ_W){1'b0}}, irq_gate_q} : '0;

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         ctrl_q          <= CTRL_RST;
         divisor_value_q <= DIV_RST;
         irq_gate_q      <= MASK_RST;
         rdata_q         <= '0;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= wdata_i;
         end
         if (wr_div) begin
            divisor_value_q <= wdata_i;
         end
         if (wr_mask) begin
            irq_gate_q <= wdata_i[IRQ_W-1:0];
         end
         rdata_q <= rd_i ? rd_mux : '0;
      end
   end

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         rxd_m_q <= 1'b1;
         rxd_s_q <= 1'b1;
         ext_m_q <= 1'b0;
         ext_s_q <= 1'b0;
      end else begin
         rxd_m_q <= rxd_i;
         rxd_s_q <= rxd_m_q;
         ext_m_q <= ext_clock_pin_i;
         ext_s_q <= ext_m_q;
      end
   end

   // ****************************************************************
   // bit rate generator
   // ****************************************************************
   assign brg_if.clk_sel   = ctrl_q[CTL_SEL_HI:CTL_SEL_LO];
   assign brg_if.ext_sel   = ctrl_q[CTL_EXT];
   assign brg_if.dbl       = ctrl_q[CTL_DBL];
   assign brg_if.half      = ctrl_q[CTL_HALF];
   assign brg_if.six       = ctrl_q[CTL_SIX];
   assign brg_if.divisor   = divisor_value_q;
   assign brg_if.ext_clk_s = ext_s_q;
   assign tick             = brg_if.tick;

   asr_brg u_brg (
      .clock_i (clock_i),
      .rstn_i  (rstn_i),
      .cfg     (brg_if.brg)
   );

   // ****************************************************************
   // receive state machine
   // ****************************************************************
   assign rx_allow = ctrl_q[CTL_RX_ALLOW];
   assign half_m1  = (brg_if.spb >> 1) - 1'b1;
   assign spb_m1   = brg_if.spb - 1'b1;
   assign stop_smp = (st_q == ST_STOP) && tick && (cnt_q >= spb_m1);
   assign done_ok  = stop_smp && rxd_s_q && !full_q;
   assign ovr_evt  = stop_smp && rxd_s_q && full_q;
   assign frm_evt  = stop_smp && !rxd_s_q;
   assign err_evt  = ovr_evt || frm_evt;

   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q;
      bit_d = bit_q;
      sh_d  = sh_q;
      if (!rx_allow) begin
         st_d = ST_IDLE;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               // held while faults are pending
               if (!fault_q && !rxd_s_q) begin
                  st_d  = ST_START;
                  cnt_d = '0;
               end
            end
            ST_START: begin
               if (tick) begin
                  if (cnt_q >= half_m1) begin
                     cnt_d = '0;
                     bit_d = '0;
                     // glitch shorter than half a bit
                     st_d  = rxd_s_q ? ST_IDLE : ST_DATA;
                  end else begin
                     cnt_d = cnt_q + 1'b1;
                  end
               end
            end
            ST_DATA: begin
               if (tick) begin
                  if (cnt_q >= spb_m1) begin
                     cnt_d = '0;
                     sh_d  = {rxd_s_q, sh_q[DW-1:1]};
                     bit_d = bit_q + 1'b1;
                     if (bit_q == DATA_LAST) begin
                        st_d = ST_STOP;
                     end
                  end else begin
                     cnt_d = cnt_q + 1'b1;
                  end
               end
            end
            ST_STOP: begin
               if (tick) begin
                  if (cnt_q >= spb_m1) begin
                     cnt_d = '0;
                     st_d  = ST_IDLE;
                  end else begin
                     cnt_d = cnt_q + 1'b1;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         st_q  <= ST_IDLE;
         cnt_q <= '0;
         bit_q <= '0;
         sh_q  <= '0;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
         bit_q <= bit_d;
         sh_q  <= sh_d;
      end
   end

   // ****************************************************************
   // status, error flags and interrupts
   // ****************************************************************
   // set wins over clear; zero clears only a flag read while set
   assign err_set = {frm_evt, ovr_evt};
   assign err_clr = {ERR_W{wr_stat}} & ~wdata_i[ERR_W-1:0] & seen_q;
   assign err_d   = err_set | (err_q & ~err_clr);
   assign seen_d  = ~err_set & ~err_clr &
                    (seen_q | ({ERR_W{rd_stat}} & err_q));
   assign full_d  = done_ok | (full_q & ~(wr_irq & wdata_i[IRQ_FULL]));

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         err_q          <= '0;
         seen_q         <= '0;
         fault_q        <= 1'b0;
         full_q         <= 1'b0;
         rxbuf_q        <= '0;
         rx_full_irq_q  <= 1'b0;
         rx_fault_irq_q <= 1'b0;
         irq_q          <= 1'b0;
      end else begin
         err_q   <= err_d;
         seen_q  <= seen_d;
         fault_q <= |err_d;
         full_q  <= full_d;
         if (done_ok) begin
            rxbuf_q <= sh_q;
         end
         rx_full_irq_q  <= full_q & ctrl_q[CTL_IRQ_ALLOW] &
                           irq_gate_q[IRQ_FULL];
         rx_fault_irq_q <= fault_q & irq_gate_q[IRQ_FAULT];
         irq_q          <= (full_q & irq_gate_q[IRQ_FULL]) |
                           (fault_q & irq_gate_q[IRQ_FAULT]);
      end
   end

   assign rdata_o        = rdata_q;
   assign rx_full_irq_o  = rx_full_irq_q;
   assign rx_fault_irq_o = rx_fault_irq_q;
   assign irq_o          = irq_q;

   // ****************************************************************
   // checks
   // ****************************************************************
   AST_RX_OFF: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !rx_allow |=> st_q == ST_IDLE)
      else $error("receiver active while disallowed");
   AST_START: assert property (@(posedge clock_i) disable iff (!rstn_i)
      st_q == ST_IDLE && rx_allow && !fault_q && !rxd_s_q
      |=> st_q == ST_START)
      else $error("start bit not taken");
   AST_STORE: assert property (@(posedge clock_i) disable iff (!rstn_i)
      done_ok |=> full_q && rxbuf_q == $past(sh_q) && !fault_q)
      else $error("byte not stored with full flag");
   AST_FAULT: assert property (@(posedge clock_i) disable iff (!rstn_i)
      err_evt && !full_q |=> fault_q && !full_q ##1
      rx_fault_irq_o == $past(irq_gate_q[IRQ_FAULT]))
      else $error("error did not raise fault only");
   AST_NO_BLIND_CLR: assert property (@(posedge clock_i) disable iff (!rstn_i)
      wr_stat && err_q[STA_FRM] && !seen_q[STA_FRM] |=> err_q[STA_FRM])
      else $error("flag cleared without prior read");
   AST_READ_CLR: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (rd_stat && err_q[STA_OVR] && !err_set[STA_OVR]) ##1
      (wr_stat && !wdata_i[STA_OVR] && !err_set[STA_OVR])
      |=> !err_q[STA_OVR])
      else $error("read then zero did not clear");
   AST_FAULT_DROP: assert property (@(posedge clock_i) disable iff (!rstn_i)
      err_q == '0 |-> !fault_q ##1 !rx_fault_irq_o)
      else $error("fault pending without errors");
   AST_HOLD: assert property (@(posedge clock_i) disable iff (!rstn_i)
      fault_q && st_q == ST_IDLE |=> st_q == ST_IDLE)
      else $error("reception while faults pending");
   AST_MIDBIT: assert property (@(posedge clock_i) disable iff (!rstn_i)
      st_q == ST_START && rx_allow && tick && cnt_q >= half_m1 && rxd_s_q
      |=> st_q == ST_IDLE)
      else $error("false start not rejected");

endmodule

// ---- tb/asr_tx_model.sv ----
// Purpose: remote transmitter driving the serial line
// Assumes: 8 data bits, no parity, one stop bit, idle high
// Notes:   bit period counted in clock_i cycles
`timescale 1ns/10ps
module asr_tx_model (
   input  wire logic clock_i,
   output logic      rxd_o
);
   initial rxd_o = 1'b1;
   // ****************************************************************
   // frame: start, data lsb first, stop (low when bad)
   // ****************************************************************
   task automatic send(input logic [7:0] b, input int per,
                       input logic bad);
      logic [9:0] f;
      f = {~bad, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clock_i);
         rxd_o <= f[i];
         repeat (per - 1) @(posedge clock_i);
      end
      @(posedge clock_i);
      rxd_o <= 1'b1;
   endtask
   // low pulse too short to pass the mid-bit start check
   task automatic glitch(input int len);
      @(posedge clock_i);
      rxd_o <= 1'b0;
      repeat (len) @(posedge clock_i);
      rxd_o <= 1'b1;
   endtask
endmodule

// ---- tb/tb_async_serial_rx_baud_gen.sv ----
// Purpose: self-checking bench of the serial receiver
// Assumes: external clock pin toggles every 4 cycles
// Notes:   random bytes, divisors and interrupt enables
`timescale 1ns/10ps
module tb_async_serial_rx_baud_gen
   import asr_pkg::*;
();
   logic          clock_i = 1'b0;
   logic          rstn_i  = 1'b0;
   logic          wr_i    = 1'b0;
   logic          rd_i    = 1'b0;
   logic          ext_pin = 1'b0;
   logic [2:0]    ext_cnt = 3'h0;
   logic [AW-1:0] addr_i  = 8'h00;
   logic [DW-1:0] wdata_i = 8'h00;
   logic [DW-1:0] rdata_o;
   logic [DW-1:0] rv;
   logic          rxd;
   logic          full_irq;
   logic          fault_irq;
   logic          irq;
   int            error_cnt = 0;
   int            checked   = 0;
   int            cyc       = 0;
   logic [7:0]    modes [8] = '{8'h00, 8'h24, 8'h48, 8'h6c,
                                8'h80, 8'h10, 8'h50, 8'h08};

   always #10 clock_i = ~clock_i;

   always @(posedge clock_i) begin
      ext_cnt <= ext_cnt + 3'h1;
      ext_pin <= ext_cnt[2];
   end

   asr_top i_dut (
      .clock_i         (clock_i),
      .rstn_i          (rstn_i),
      .addr_i          (addr_i),
      .wdata_i         (wdata_i),
      .wr_i            (wr_i),
      .rd_i            (rd_i),
      .rdata_o         (rdata_o),
      .rxd_i           (rxd),
      .ext_clock_pin_i (ext_pin),
      .rx_full_irq_o   (full_irq),
      .rx_fault_irq_o  (fault_irq),
      .irq_o           (irq)
   );

   asr_tx_model i_tx (
      .clock_i (clock_i),
      .rxd_o   (rxd)
   );

   // ****************************************************************
   // register port, checks, expectations
   // ****************************************************************
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clock_i);
      wr_i    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clock_i);
      rd_i   <= 1'b0;
      @(posedge clock_i);
      d = rdata_o;
   endtask

   // read, then a zero write at once behind it
   task automatic rd_clr(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock_i);
      addr_i  <= a;
      rd_i    <= 1'b1;
      @(posedge clock_i);
      rd_i    <= 1'b0;
      wdata_i <= 8'h00;
      wr_i    <= 1'b1;
      @(posedge clock_i);
      wr_i    <= 1'b0;
      d = rdata_o;
   endtask

   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] s);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic rchk(input string n, input logic [7:0] a,
                       input logic [7:0] e);
      rd(a, rv);
      chk(n, e, rv);
   endtask

   function automatic int bitper(input logic [7:0] c, input int n);
      int s;
      s = c[CTL_SIX] ? 6 : c[CTL_EXT] ? (c[CTL_HALF] ? 8 : 16)
        : (c[CTL_DBL] & c[CTL_HALF]) ? 8
        : (c[CTL_DBL] ^ c[CTL_HALF]) ? 16 : 32;
      return c[CTL_EXT] ? s * 8 : s * (n + 1) * (1 << (2 * c[3:2]));
   endfunction

   task automatic rx_one(input logic [7:0] c, input int n);
      logic [7:0] b;
      b = 8'($urandom);
      wr(ADDR_DIV, 8'(n));
      wr(ADDR_CTRL, c);
      i_tx.send(b, bitper(c, n), 1'b0);
      repeat (12) @(posedge clock_i);
      chk("full_irq", {7'h0, c[CTL_IRQ_ALLOW]}, {7'h0, full_irq});
      chk("irq", 8'h01, {7'h0, irq});
      rchk("pending", ADDR_IRQ, 8'h01);
      rchk("data", ADDR_DATA, b);
      wr(ADDR_IRQ, 8'h01);
   endtask

   task automatic print_verdict;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         error_cnt++;
         print_verdict();
      end
   end

   initial begin
      void'($urandom(32'hc3b2));
      repeat (20) @(posedge clock_i);
      rstn_i <= 1'b1;
      wr(8'h18, 8'hff);
      for (int a = 0; a < 28; a += 4) begin
         rchk("reset", 8'(a), 8'h00);
      end
      wr(ADDR_MASK, 8'h03);
      wr(ADDR_CTRL, 8'h02);
      i_tx.send(8'h5a, 32, 1'b0);
      repeat (12) @(posedge clock_i);
      rchk("off", ADDR_IRQ, 8'h00);
      wr(ADDR_CTRL, 8'h03);
      i_tx.send(8'ha5, 32, 1'b1);
      repeat (12) @(posedge clock_i);
      chk("fault_irq", 8'h01, {7'h0, fault_irq});
      rchk("pending", ADDR_IRQ, 8'h02);
      wr(ADDR_MASK, 8'h01);
      repeat (2) @(posedge clock_i);
      chk("masked", 8'h00, {6'h0, fault_irq, irq});
      wr(ADDR_MASK, 8'h03);
      wr(ADDR_STAT, 8'h00);
      rchk("status", ADDR_STAT, 8'h02);
      wr(ADDR_STAT, 8'h00);
      repeat (3) @(posedge clock_i);
      chk("fault_irq", 8'h00, {7'h0, fault_irq});
      rchk("pending", ADDR_IRQ, 8'h00);
      for (int i = 0; i < 8; i++) begin
         rx_one(modes[i] | 8'h01 | 8'(($urandom % 2) << 1),
                int'($urandom % 2));
      end
      wr(ADDR_DIV, 8'h00);
      wr(ADDR_CTRL, 8'h03);
      i_tx.send(8'h3c, 32, 1'b0);
      i_tx.send(8'hc3, 32, 1'b0);
      repeat (12) @(posedge clock_i);
      chk("ovr_irq", 8'h01, {7'h0, fault_irq});
      rchk("ovr_pend", ADDR_IRQ, 8'h03);
      rchk("ovr_keep", ADDR_DATA, 8'h3c);
      rd_clr(ADDR_STAT, rv);
      chk("ovr_stat", 8'h01, rv);
      rchk("ovr_clr", ADDR_STAT, 8'h00);
      wr(ADDR_IRQ, 8'h01);
      i_tx.glitch(8);
      repeat (40) @(posedge clock_i);
      rchk("glitch", ADDR_IRQ, 8'h00);
      print_verdict();
   end
endmodule
